// [rtl/breaker_failure_retrip_logic.sv]
`timescale 1ns/1ps
`default_nettype none
module breaker_failure_retrip_logic #(
	parameter int unsigned TICK_CYCLES = breaker_fail_pkg::TICK_CYCLES,
	parameter int unsigned LOG_DEPTH   = breaker_fail_pkg::LOG_DEPTH
) (
	input  wire logic                          core_clk,
	input  wire logic                          rst_b,
	input  wire breaker_fail_pkg::currents_t   currents,
	input  wire breaker_fail_pkg::settings_t   settings,
	input  wire logic                          out_monitor,
	input  wire logic                          trip_signal_in,
	input  wire logic                          block_in,
	input  wire logic [breaker_fail_pkg::TS_W-1:0] timestamp,
	input  wire logic                          counter_clear,
	input  wire logic [3:0]                    log_age,
	output logic                               start,
	output logic                               repeat_trip_output,
	output logic                               breaker_fail_output,
	output logic                               blocked,
	output logic                               event_valid,
	output breaker_fail_pkg::event_t           event_out,
	output breaker_fail_pkg::counters_t        counters,
	output logic [3:0]                         log_count,
	output breaker_fail_pkg::record_t          log_record
);
	import breaker_fail_pkg::*;

	localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

	generate
		if (TICK_CYCLES < 1 || LOG_DEPTH < 1 || LOG_DEPTH > 15) begin : g_bad
			$error("unsupported tick count or log depth");
		end
	endgenerate

	function automatic logic [CUR_W-1:0] max2(input logic [CUR_W-1:0] a,
		input logic [CUR_W-1:0] b);
		max2 = (a > b) ? a : b;
	endfunction

	function automatic logic [DLY_W-1:0] left(input logic [DLY_W-1:0] dly,
		input logic [DLY_W-1:0] el);
		left = (dly > el) ? dly - el : '0;
	endfunction

	function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] c,
		input logic inc, input logic clr);
		logic [CNT_W-1:0] base;
		base = clr ? '0 : c;
		bump = (inc && base != '1) ? base + 1'b1 : base;
	endfunction

	// timing state
	logic [TW-1:0]         tick_cnt_q, tick_cnt_d;
	logic [DLY_W-1:0]      elapsed_q, elapsed_d;
	logic [NUM_EVENTS-1:0] state_q, state_d;
	// event and log state
	logic [NUM_EVENTS-1:0] pend_on_q, pend_on_d, pend_off_q, pend_off_d;
	logic                  event_valid_d;
	event_t                event_d;
	counters_t             counters_d;
	logic [3:0]            wptr_q, wptr_d, log_count_d;
	logic                  wr_en;
	record_t               wr_rec;
	logic [3:0]            rd_addr;

	logic                  tick;
	logic [CUR_W-1:0]      max_phase;
	logic                  phase_pu, res_pu, cur_pu, pickup;
	logic                  start_n, retrip_n, fail_n, blocked_n;
	logic [NUM_EVENTS-1:0] rise, fall, gnt_on, gnt_off;
	logic [4:0]            age_sum;

	always_comb begin
		tick = (tick_cnt_q == '0);
		tick_cnt_d = tick ? TW'(TICK_CYCLES - 1) : tick_cnt_q - 1'b1;
		max_phase = max2(max2(currents.phase_l1, currents.phase_l2),
			currents.phase_l3);
		phase_pu = max_phase > settings.phase_pickup_threshold;
		res_pu = currents.residual > settings.residual_pickup_threshold;
		cur_pu = phase_pu | res_pu;
		case (settings.mode)
			MODE_CURRENT:     pickup = cur_pu;
			MODE_CUR_AND_OUT: pickup = cur_pu & out_monitor;
			MODE_CUR_OR_OUT:  pickup = cur_pu | out_monitor;
			MODE_SIGNAL:      pickup = trip_signal_in;
			MODE_SIG_CUR_OUT: pickup = trip_signal_in | cur_pu | out_monitor;
			default:          pickup = cur_pu;
		endcase
		blocked_n = pickup & block_in;
		start_n = pickup & ~block_in;
		elapsed_d = elapsed_q;
		state_d = state_q;
		if (tick) begin
			if (start_n && state_q[EV_START]) begin
				elapsed_d = (elapsed_q == '1) ? elapsed_q : elapsed_q + 1'b1;
			end else begin
				elapsed_d = '0;
			end
		end
		retrip_n = start_n & settings.retrip_enable &
			(elapsed_d >= settings.repeat_trip_delay);
		fail_n = start_n & (elapsed_d >= settings.breaker_fail_delay);
		if (tick) begin
			state_d = {res_pu, phase_pu, trip_signal_in, out_monitor,
				blocked_n, fail_n, retrip_n, start_n};
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			tick_cnt_q <= '0;
			elapsed_q  <= '0;
			state_q    <= '0;
		end else begin
			tick_cnt_q <= tick_cnt_d;
			elapsed_q  <= elapsed_d;
			state_q    <= state_d;
		end
	end

	assign start               = state_q[EV_START];
	assign repeat_trip_output  = state_q[EV_RETRIP];
	assign breaker_fail_output = state_q[EV_FAIL];
	assign blocked             = state_q[EV_BLOCK];

	// one pending edge is reported per clock, ON edges first, low id first
	always_comb begin
		rise = state_d & ~state_q;
		fall = ~state_d & state_q;
		gnt_on = pend_on_q & (~pend_on_q + 1'b1);
		gnt_off = (pend_on_q == '0) ? pend_off_q & (~pend_off_q + 1'b1) : '0;
		pend_on_d = (pend_on_q & ~gnt_on) | rise;
		pend_off_d = (pend_off_q & ~gnt_off) | fall;
		event_d = event_out;
		event_valid_d = 1'b0;
		for (int i = 0; i < NUM_EVENTS; i++) begin
			if (gnt_on[i] || gnt_off[i]) begin
				event_d.id = event_id_t'(i);
				event_d.is_on = gnt_on[i];
				event_d.stamp = timestamp;
				event_valid_d = gnt_on[i] ? settings.event_mask[2*i]
					: settings.event_mask[2*i+1];
			end
		end
		wr_en = (gnt_on != '0);
		wr_rec.stamp = timestamp;
		wr_rec.id = event_d.id;
		wr_rec.max_phase = max_phase;
		wr_rec.residual = currents.residual;
		wr_rec.retrip_left = settings.retrip_enable ?
			left(settings.repeat_trip_delay, elapsed_q) : '0;
		wr_rec.fail_left = left(settings.breaker_fail_delay, elapsed_q);
		wr_rec.setting_group = settings.setting_group;
		wptr_d = wptr_q;
		log_count_d = log_count;
		if (wr_en) begin
			wptr_d = (32'(wptr_q) == LOG_DEPTH - 1) ? '0 : wptr_q + 1'b1;
			if (32'(log_count) < LOG_DEPTH) begin
				log_count_d = log_count + 1'b1;
			end
		end
		// age 0 is the newest record
		age_sum = 5'(wptr_q) + 5'(LOG_DEPTH) - 5'd1 - 5'(log_age);
		rd_addr = (32'(age_sum) >= LOG_DEPTH) ? 4'(age_sum - 5'(LOG_DEPTH))
			: age_sum[3:0];
		counters_d.retrip = bump(counters.retrip, rise[EV_RETRIP],
			counter_clear);
		counters_d.fail = bump(counters.fail, rise[EV_FAIL], counter_clear);
		counters_d.start = bump(counters.start, rise[EV_START],
			counter_clear);
		counters_d.blocked = bump(counters.blocked, rise[EV_BLOCK],
			counter_clear);
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pend_on_q   <= '0;
			pend_off_q  <= '0;
			event_out   <= '0;
			event_valid <= 1'b0;
			counters    <= '0;
			wptr_q      <= '0;
			log_count   <= '0;
		end else begin
			pend_on_q   <= pend_on_d;
			pend_off_q  <= pend_off_d;
			event_out   <= event_d;
			event_valid <= event_valid_d;
			counters    <= counters_d;
			wptr_q      <= wptr_d;
			log_count   <= log_count_d;
		end
	end

	breaker_fail_record_ram #(
		.DEPTH (LOG_DEPTH),
		.WIDTH ($bits(record_t)),
		.AW    (4)
	) u_log (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.wr_en    (wr_en),
		.wr_addr  (wptr_q),
		.wr_data  (wr_rec),
		.rd_addr  (rd_addr),
		.rd_data  (log_record)
	);
endmodule // breaker_failure_retrip_logic
`default_nettype wire

// [include/breaker_fail_pkg.sv]
// How it works
// - current-only mode: current pick-up starts both timers, trip output not watched
// - current-only: repeat trip after retrip delay, breaker fail after fail delay
// - current-only: timers clear once both currents drop below thresholds
// - current-and-output: timers held until monitored trip output goes active
// - current-and-output: timers reset when current drops or trip output drops
// - current-or-output: either condition starts timing and keeps pick-up
// - current-or-output: reset only when current low and trip output released
// - without repeat trip stage only the breaker fail timer matters
// - signal mode: digital input starts breaker fail timing, fires if held
// - signal mode may add current and output monitoring as pick-up terms
// - time-stamped ON and OFF events for eight states, masked per event
// - clearable counters for repeat trip, breaker fail, start and blocked
// - each ON event stores a record; only the latest twelve kept
// - retrip delay in 5 ms steps, default 100 ms
// - breaker fail delay programmable, default 200 ms
// - block at pick-up gives blocked, block after start resets start
// - retrip disabled suppresses repeat trip output and its timing
package breaker_fail_pkg;
	localparam int unsigned CLK_HZ      = 40_000_000;
	localparam int unsigned TICK_US     = 5000;
	localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
	localparam int unsigned CUR_W       = 16;
	localparam int unsigned DLY_W       = 19;
	localparam int unsigned TS_W        = 32;
	localparam int unsigned GRP_W       = 3;
	localparam int unsigned CNT_W       = 16;
	localparam int unsigned LOG_DEPTH   = 12;
	localparam int unsigned NUM_EVENTS  = 8;
	localparam int unsigned RETRIP_DELAY_DEF_US = 100_000;
	localparam int unsigned FAIL_DELAY_DEF_US   = 200_000;
	// defaults in program cycle ticks
	localparam logic [DLY_W-1:0] REPEAT_TRIP_DELAY_DEF =
		DLY_W'(RETRIP_DELAY_DEF_US / TICK_US);
	localparam logic [DLY_W-1:0] BREAKER_FAIL_DELAY_DEF =
		DLY_W'(FAIL_DELAY_DEF_US / TICK_US);

	typedef enum logic [2:0] {
		MODE_CURRENT     = 3'h0,
		MODE_CUR_AND_OUT = 3'h1,
		MODE_CUR_OR_OUT  = 3'h2,
		MODE_SIGNAL      = 3'h3,
		MODE_SIG_CUR_OUT = 3'h4
	} mode_t;

	typedef enum logic [2:0] {
		EV_START    = 3'h0,
		EV_RETRIP   = 3'h1,
		EV_FAIL     = 3'h2,
		EV_BLOCK    = 3'h3,
		EV_OUT_MON  = 3'h4,
		EV_SIGNAL   = 3'h5,
		EV_PHASE    = 3'h6,
		EV_RESIDUAL = 3'h7
	} event_id_t;

	typedef struct packed {
		logic [CUR_W-1:0] phase_l1;
		logic [CUR_W-1:0] phase_l2;
		logic [CUR_W-1:0] phase_l3;
		logic [CUR_W-1:0] residual;
	} currents_t;

	// event_mask bit 2*id stores ON, bit 2*id+1 stores OFF
	typedef struct packed {
		mode_t                   mode;
		logic                    retrip_enable;
		logic [CUR_W-1:0]        phase_pickup_threshold;
		logic [CUR_W-1:0]        residual_pickup_threshold;
		logic [DLY_W-1:0]        repeat_trip_delay;
		logic [DLY_W-1:0]        breaker_fail_delay;
		logic [GRP_W-1:0]        setting_group;
		logic [2*NUM_EVENTS-1:0] event_mask;
	} settings_t;

	typedef struct packed {
		event_id_t        id;
		logic             is_on;
		logic [TS_W-1:0]  stamp;
	} event_t;

	typedef struct packed {
		logic [TS_W-1:0]  stamp;
		event_id_t        id;
		logic [CUR_W-1:0] max_phase;
		logic [CUR_W-1:0] residual;
		logic [DLY_W-1:0] retrip_left;
		logic [DLY_W-1:0] fail_left;
		logic [GRP_W-1:0] setting_group;
	} record_t;

	typedef struct packed {
		logic [CNT_W-1:0] retrip;
		logic [CNT_W-1:0] fail;
		logic [CNT_W-1:0] start;
		logic [CNT_W-1:0] blocked;
	} counters_t;
endpackage

// [rtl/breaker_fail_record_ram.sv]
`timescale 1ns/1ps
`default_nettype none
module breaker_fail_record_ram #(
	parameter int unsigned DEPTH = 12,
	parameter int unsigned WIDTH = 8,
	parameter int unsigned AW    = 4
) (
	input  wire logic             core_clk,
	input  wire logic             rst_b,
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] rd_data_d;

	always_comb begin
		rd_data_d = '0;
		if (32'(rd_addr) < DEPTH) begin
			rd_data_d = mem_q[rd_addr];
		end
	end

	always_ff @(posedge core_clk) begin
		if (wr_en && 32'(wr_addr) < DEPTH) begin
			mem_q[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data <= '0;
		end else begin
			rd_data <= rd_data_d;
		end
	end
endmodule // breaker_fail_record_ram
`default_nettype wire

// [verification/breaker_fail_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module bf_retrip_chk
	import breaker_fail_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = 2,
	parameter int unsigned LOG_DEPTH   = 12
) (
	input wire logic                        core_clk,
	input wire logic                        rst_b,
	input wire breaker_fail_pkg::currents_t currents,
	input wire breaker_fail_pkg::settings_t settings,
	input wire logic                        out_monitor,
	input wire logic                        trip_signal_in,
	input wire logic                        block_in,
	input wire logic                        counter_clear,
	input wire logic                        start,
	input wire logic                        repeat_trip_output,
	input wire logic                        breaker_fail_output,
	input wire logic                        blocked,
	input wire breaker_fail_pkg::counters_t counters,
	input wire logic [3:0]                  log_count
);
	logic [19:0] cnt_q, cnt_d;
	logic        tk, cur;
	mode_t       m;
	// mirror of the program cycle tick
	always_comb begin
		cnt_d = (cnt_q == 20'(TICK_CYCLES - 1)) ? '0 : cnt_q + 20'h1;
		tk = cnt_q == '0;
		m = settings.mode;
		cur = currents.phase_l1 > settings.phase_pickup_threshold
			|| currents.phase_l2 > settings.phase_pickup_threshold
			|| currents.phase_l3 > settings.phase_pickup_threshold
			|| currents.residual > settings.residual_pickup_threshold;
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	tick_only_a: assert property (
		!tk |=> $stable({start, repeat_trip_output, breaker_fail_output, blocked}))
		else $error("output moved between ticks");
	cur_start_a: assert property (
		tk && m == MODE_CURRENT && cur && !block_in |=> start)
		else $error("current pick-up did not start");
	cur_clear_a: assert property (
		tk && m == MODE_CURRENT && !cur |=> !start && !breaker_fail_output)
		else $error("timers not cleared on low current");
	and_hold_a: assert property (
		tk && m == MODE_CUR_AND_OUT && !(cur && out_monitor) |=> !start)
		else $error("and mode timed without both terms");
	or_start_a: assert property (
		tk && m == MODE_CUR_OR_OUT && (cur || out_monitor) && !block_in |=> start)
		else $error("or mode did not start");
	sig_start_a: assert property (
		tk && m == MODE_SIGNAL && trip_signal_in && !block_in |=> start)
		else $error("signal mode did not start");
	block_stop_a: assert property (
		tk && block_in |=> !start) else $error("start while blocked");
	retrip_off_a: assert property (
		tk && !settings.retrip_enable |=> !repeat_trip_output)
		else $error("repeat trip while disabled");
	fail_start_a: assert property (
		breaker_fail_output || repeat_trip_output |-> start)
		else $error("trip output without start");
	clear_cnt_a: assert property (
		counter_clear |=> counters.fail <= 16'h1 && counters.start <= 16'h1)
		else $error("counters not cleared");
	log_depth_a: assert property (
		log_count <= LOG_DEPTH) else $error("log count above depth");
endmodule // bf_retrip_chk
bind breaker_failure_retrip_logic bf_retrip_chk #(
	.TICK_CYCLES(TICK_CYCLES),
	.LOG_DEPTH(LOG_DEPTH)
) chk (.core_clk, .rst_b, .currents, .settings, .out_monitor, .trip_signal_in,
	.block_in, .counter_clear, .start, .repeat_trip_output, .breaker_fail_output,
	.blocked, .counters, .log_count);
`default_nettype wire

// [verification/primary_stage_model.sv]
`timescale 1ns/1ps
`default_nettype none
module primary_stage_model #(
	parameter int unsigned TK = 4
) (
	input wire logic       core_clk,
	input wire logic       fault,
	input wire logic [2:0] lag,
	output logic           out_monitor
);
	int n = 0;
	// trip contact closes lag ticks after the fault, opens with it
	always @(posedge core_clk) n <= fault ? n + 1 : 0;
	assign out_monitor = fault && n >= lag * TK;
endmodule // primary_stage_model
`default_nettype wire

// [verification/tb_breaker_failure_retrip_logic.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_breaker_failure_retrip_logic;
	import breaker_fail_pkg::*;
	localparam int TK = 4;
	logic       core_clk = 0, rst_b = 0, flt = 0, trip_signal_in = 0;
	logic       block_in = 0, counter_clear = 0, out_monitor, event_valid;
	logic       start, repeat_trip_output, breaker_fail_output, blocked;
	logic [2:0] lag = 0;
	logic [3:0] log_age = 0, log_count;
	currents_t  currents = '0;
	settings_t  settings = '0;
	event_t     event_out;
	counters_t  counters, ex = '0;
	record_t    log_record;
	int         num_errors = 0, n_compared = 0, cyc = 0, evs = 0;
	always #12.5 core_clk = ~core_clk;
	breaker_failure_retrip_logic #(.TICK_CYCLES(TK)) uut (.core_clk, .rst_b,
		.currents, .settings, .out_monitor, .trip_signal_in, .block_in,
		.timestamp(32'(cyc)), .counter_clear, .log_age, .start,
		.repeat_trip_output, .breaker_fail_output, .blocked, .event_valid,
		.event_out, .counters, .log_count, .log_record);
	primary_stage_model #(.TK(TK)) far (.core_clk, .fault(flt), .lag,
		.out_monitor);
	task automatic final_report();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			final_report();
		end
	end
	always @(negedge core_clk) begin
		if (event_valid === 1'b1 && event_out.id === EV_START && event_out.is_on)
			evs++;
	end
	task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
		n_compared++;
		if (e !== g) begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic ticks(int n);
		repeat (n * TK) @(negedge core_clk);
	endtask
	function automatic logic pu(mode_t m, logic c, logic o, logic s);
		case (m)
			MODE_CURRENT: return c;
			MODE_CUR_AND_OUT: return c && o;
			MODE_CUR_OR_OUT: return c || o;
			MODE_SIGNAL: return s;
			default: return s || c || o;
		endcase
	endfunction
	function automatic logic cu(currents_t x);
		return x.phase_l1 > 16'h0100 || x.phase_l2 > 16'h0100
			|| x.phase_l3 > 16'h0100 || x.residual > 16'h0080;
	endfunction
	task automatic run(int i);
		logic s, r, f, b, p, e;
		int   el, k;
		{s, r, f, b, el} = '0;
		k = $urandom_range(1, 6);
		settings.mode = mode_t'(3'(i < 5 ? i : $urandom_range(0, 4)));
		settings.retrip_enable = 1'($urandom);
		settings.repeat_trip_delay = 19'($urandom_range(0, 3));
		settings.breaker_fail_delay = 19'($urandom_range(0, 5));
		settings.event_mask = 16'($urandom) | 16'h0001;
		currents = {$urandom, $urandom} & {4{16'h01ff}};
		if (i % 4 == 0) currents.phase_l1 = 16'h0100;
		trip_signal_in = 1'($urandom);
		block_in = i > 4 && $urandom_range(0, 3) == 0;
		flt = 1'($urandom);
		lag = 3'($urandom_range(0, 7));
		for (int t = 1; t <= k; t++) begin
			p = pu(settings.mode, cu(currents), flt && t > lag, trip_signal_in);
			if (p && !block_in && !s) ex.start++;
			if (p && block_in && !b) ex.blocked++;
			el = (p && !block_in && s) ? el + 1 : 0;
			s = p && !block_in;
			b = p && block_in;
			e = s && settings.retrip_enable && el >= settings.repeat_trip_delay;
			if (e && !r) ex.retrip++;
			r = e;
			e = s && el >= settings.breaker_fail_delay;
			if (e && !f) ex.fail++;
			f = e;
		end
		ticks(k);
		chk("start", 64'(s), 64'(start));
		chk("retrip", 64'(r), 64'(repeat_trip_output));
		chk("fail", 64'(f), 64'(breaker_fail_output));
		chk("blocked", 64'(b), 64'(blocked));
		currents = '0;
		{flt, trip_signal_in, block_in} = '0;
		log_age = 4'($urandom);
		ticks(1);
		chk("released", 64'h0, 64'({start, repeat_trip_output, breaker_fail_output, blocked}));
	endtask
	// directed case: signal mode, records read back by age, masked OFF event
	task automatic rec_case();
		int      c0;
		record_t x;
		settings.mode = MODE_SIGNAL;
		settings.retrip_enable = 1'b1;
		settings.repeat_trip_delay = 19'h0_0003;
		settings.breaker_fail_delay = 19'h0_0005;
		settings.setting_group = 3'h5;
		settings.event_mask = 16'hffff;
		currents = '0;
		currents.phase_l2 = 16'h0050;
		currents.residual = 16'h0040;
		trip_signal_in = 1'b1;
		log_age = 4'h0;
		c0 = cyc;
		x.stamp = 32'(c0 + 2);
		x.id = EV_SIGNAL;
		x.max_phase = 16'h0050;
		x.residual = 16'h0040;
		x.retrip_left = 19'h0_0003;
		x.fail_left = 19'h0_0005;
		x.setting_group = 3'h5;
		repeat (2) @(negedge core_clk);
		chk("event_valid", 64'h1, 64'(event_valid));
		chk("event_on", 64'({EV_START, 1'b1, 32'(c0 + 1)}), 64'(event_out));
		repeat (2) @(negedge core_clk);
		chk("record_new_hi", 64'(x >> 64), 64'(log_record >> 64));
		chk("record_new_lo", 64'(x), 64'(log_record));
		x.stamp = 32'(c0 + 1);
		x.id = EV_START;
		log_age = 4'h1;
		@(negedge core_clk);
		chk("record_old_hi", 64'(x >> 64), 64'(log_record >> 64));
		chk("record_old_lo", 64'(x), 64'(log_record));
		trip_signal_in = 1'b0;
		settings.event_mask = 16'hf7ff;
		repeat (5) @(negedge core_clk);
		chk("event_off", 64'({EV_START, 1'b0, 32'(c0 + 9)}), 64'(event_out));
		@(negedge core_clk);
		chk("masked_valid", 64'h0, 64'(event_valid));
		chk("event_masked", 64'({EV_SIGNAL, 1'b0, 32'(c0 + 10)}), 64'(event_out));
	endtask
	initial begin
		void'($urandom(17662));
		settings.phase_pickup_threshold = 16'h0100;
		settings.residual_pickup_threshold = 16'h0080;
		repeat (12) @(negedge core_clk);
		rst_b = 1;
		for (int i = 0; i < 60; i++) run(i);
		ticks(10);
		chk("counters", ex, counters);
		chk("start_on_events", 64'(ex.start), 64'(evs));
		chk("log_count", 64'(LOG_DEPTH), 64'(log_count));
		rec_case();
		counter_clear = 1;
		@(negedge core_clk);
		counter_clear = 0;
		chk("cleared", 64'h0, counters);
		final_report();
	end
endmodule // tb_breaker_failure_retrip_logic
`default_nettype wire
